// [rtl/can_mask_params.svh]
// Register indices, field positions and bus codes of the CAN mask and object map block.
// Assumes that it is included by bare name into the design file, once per compile unit.
`ifndef CAN_MASK_PARAMS_SVH
`define CAN_MASK_PARAMS_SVH

// ============================================================================
// Register indices (byte address on the bus is four times the index).
`define IDX_CONTROL 16'hF700
`define IDX_BIT_TIMING_LOW 16'hF704
`define IDX_BIT_TIMING_HIGH 16'hF705
`define IDX_STD_MASK_LOW 16'hF706
`define IDX_STD_MASK_HIGH 16'hF707
`define IDX_EXT_MASK_BYTE3 16'hF708
`define IDX_EXT_MASK_BYTE2 16'hF709
`define IDX_EXT_MASK_BYTE1 16'hF70A
`define IDX_EXT_MASK_BYTE0 16'hF70B
`define IDX_LAST_MASK_BYTE3 16'hF70C
`define IDX_LAST_MASK_BYTE2 16'hF70D
`define IDX_LAST_MASK_BYTE1 16'hF70E
`define IDX_LAST_MASK_BYTE0 16'hF70F
`define IDX_OBJ_FIRST 16'hF710
`define IDX_OBJ_LAST 16'hF7FF

// ============================================================================
// Offsets inside a message object.
`define OFS_CTRL_LOW 4'h0
`define OFS_CTRL_HIGH 4'h1
`define OFS_ARB3 4'h2
`define OFS_ARB2 4'h3
`define OFS_ARB1 4'h4
`define OFS_ARB0 4'h5
`define OFS_CONFIG 4'h6
`define OFS_RESERVED 4'hF
`define OBJ_LAST_NUM 4'hF

// ============================================================================
// Field positions.
`define CTL_INIT_BIT 0
`define CTL_CCE_BIT 6
`define CFG_XTD_BIT 2
`define ELEM_VALID 0
`define ELEM_TXIE 1
`define ELEM_TXRQ 5
`define BTL_SJW_HI 7
`define BTL_SJW_LO 6
`define BTL_BRP_HI 5
`define BTL_BRP_LO 0
`define BTH_SEG2_HI 6
`define BTH_SEG2_LO 4
`define BTH_SEG1_HI 3
`define BTH_SEG1_LO 0
`define SEG1_MIN 4'h2
`define SEG2_MIN 3'h1
`define STDH_FILL 5'h1F
`define LOW3_ZERO 3'h0

// ============================================================================
// Reset values and bus answers.
`define CONTROL_RESET 8'h01
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define PAIR_SET 2'h2
`define PAIR_CLEAR 2'h1

`endif

// [rtl/can_mask_pkg.sv]
// Types shared by the CAN mask and object map block.
// Assumes nothing beyond a SystemVerilog compiler.
package can_mask_pkg;

    // ========================================================================
    // Phases of one nominal bit.
    typedef enum logic [1:0] {
        PH_SYNC,
        PH_BEFORE,
        PH_AFTER
    } bit_phase_t;

    typedef logic [7:0] byte_t;

endpackage

// [rtl/can_acceptance_mask_and_object_map.sv]
// CAN controller configuration side: bit timing, acceptance masks, message object map and filter.
// Assumes an AXI4-Lite master on core_clk, frames offered by a protocol engine one cycle wide,
// and bus edges already synchronous to core_clk.
`timescale 1ns/1ps
`include "can_mask_params.svh"

module can_acceptance_mask_and_object_map (
    input wire logic core_clk, // Oscillator clock, 250 MHz.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic [17:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [17:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic frameValid, // One-cycle strobe: a received identifier is offered.
    input wire logic frameExt, // Identifier extension bit of the offered frame.
    input wire logic [28:0] frameId, // Identifier; standard frames use bits 28..18.
    output logic acceptValid, // One-cycle pulse: the offered frame found an object.
    output logic [3:0] acceptObject, // Number of the accepting object.
    input wire logic busEdge, // Recessive to dominant edge seen on the bus.
    output logic quantumTick, // One-cycle pulse at each time quantum.
    output logic bitStart, // One-cycle pulse at the start of each nominal bit.
    output logic samplePoint, // One-cycle pulse at the sample point.
    output logic initMode // Controller held in initialisation.
);

    // ========================================================================
    // Register storage.
    logic [7:0] controlReg;
    logic [7:0] bitTimingLow;
    logic [6:0] bitTimingHigh;
    logic [10:0] stdMask;
    logic [28:0] extMask;
    logic [28:0] lastMask;
    can_mask_pkg::byte_t objMem [16:255];
    logic [7:0] ctlElem [1:15];

    // ========================================================================
    // AXI4-Lite slave: address and data are held independently, then written.
    logic awHeld;
    logic wHeld;
    logic [15:0] awIdx;
    logic awAligned;
    logic [7:0] wByte;
    logic wLane0;
    logic doWrite;
    logic wrMapped;
    logic rdMapped;
    logic [15:0] arIdx;
    logic [7:0] rdByte;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign arIdx = s_axi_araddr[17:2];

    // Unmapped or misaligned accesses answer SLVERR and change nothing.
    function automatic logic is_mapped(input logic [15:0] idx);
        is_mapped = (idx == `IDX_CONTROL) ||
            (idx >= `IDX_BIT_TIMING_LOW && idx <= `IDX_OBJ_LAST && idx[3:0] != `OFS_RESERVED) ||
            (idx == `IDX_LAST_MASK_BYTE0);
    endfunction

    assign wrMapped = awAligned && is_mapped(awIdx);
    assign rdMapped = (s_axi_araddr[1:0] == 2'h0) && is_mapped(arIdx);

    // Capture of the write address.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            awHeld <= 1'b0;
            awIdx <= 16'h0000;
            awAligned <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awIdx <= s_axi_awaddr[17:2];
            awAligned <= (s_axi_awaddr[1:0] == 2'h0);
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    // Capture of the write data; only the low byte lane carries a register.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wHeld <= 1'b0;
            wByte <= 8'h00;
            wLane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wByte <= s_axi_wdata[7:0];
            wLane0 <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    // Write response, one cycle after both halves are held.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wrEn;
    assign wrEn = doWrite && wrMapped && wLane0;

    // ========================================================================
    // Control register: init and configuration change enable.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            controlReg <= `CONTROL_RESET;
        end else if (wrEn && awIdx == `IDX_CONTROL) begin
            controlReg <= wByte;
        end
    end

    logic cce;
    assign cce = controlReg[`CTL_CCE_BIT];
    assign initMode = controlReg[`CTL_INIT_BIT];

    // Bit timing bytes; their contents are undefined after reset, so they carry no reset.
    always_ff @(posedge core_clk) begin
        if (wrEn && cce && awIdx == `IDX_BIT_TIMING_LOW) begin
            bitTimingLow <= wByte;
        end
        if (wrEn && cce && awIdx == `IDX_BIT_TIMING_HIGH) begin
            bitTimingHigh <= wByte[6:0];
        end
    end

    // Global and last-object masks; undefined after reset.
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            case (awIdx)
                `IDX_STD_MASK_LOW: stdMask[10:3] <= wByte;
                `IDX_STD_MASK_HIGH: stdMask[2:0] <= wByte[7:5];
                `IDX_EXT_MASK_BYTE3: extMask[28:21] <= wByte;
                `IDX_EXT_MASK_BYTE2: extMask[20:13] <= wByte;
                `IDX_EXT_MASK_BYTE1: extMask[12:5] <= wByte;
                `IDX_EXT_MASK_BYTE0: extMask[4:0] <= wByte[7:3];
                `IDX_LAST_MASK_BYTE3: lastMask[28:21] <= wByte;
                `IDX_LAST_MASK_BYTE2: lastMask[20:13] <= wByte;
                `IDX_LAST_MASK_BYTE1: lastMask[12:5] <= wByte;
                `IDX_LAST_MASK_BYTE0: lastMask[4:0] <= wByte[7:3];
                default: ;
            endcase
        end
    end

    // ========================================================================
    // Message objects: the low index byte is object number and offset together.
    logic objWrite;
    logic [3:0] wrObj;
    logic [3:0] wrOfs;
    assign objWrite = wrEn && awIdx >= `IDX_OBJ_FIRST;
    assign wrObj = awIdx[7:4];
    assign wrOfs = awIdx[3:0];

    // Arbitration, configuration and data bytes; kept through reset like the hardware.
    always_ff @(posedge core_clk) begin
        if (objWrite && wrOfs >= `OFS_ARB3) begin
            objMem[awIdx[7:0]] <= wByte;
        end
    end

    // Control elements: one flop per element, updated from its bit pair; no reset.
    genvar gObj;
    genvar gEl;
    generate
        for (gObj = 1; gObj < 16; gObj++) begin : g_ctl
            for (gEl = 0; gEl < 8; gEl++) begin : g_el
                logic [1:0] pair;
                logic hardZero;
                assign pair = wByte[(gEl % 4) * 2 + 1 -: 2];
                // Object fifteen cannot transmit, so its transmit elements stay cleared.
                assign hardZero = (gObj == `OBJ_LAST_NUM) && (gEl == `ELEM_TXIE || gEl == `ELEM_TXRQ);
                always_ff @(posedge core_clk) begin
                    if (hardZero) begin
                        ctlElem[gObj][gEl] <= 1'b0;
                    end else if (objWrite && wrObj == gObj && wrOfs == gEl / 4) begin
                        if (pair == `PAIR_SET) begin
                            ctlElem[gObj][gEl] <= 1'b1;
                        end else if (pair == `PAIR_CLEAR) begin
                            ctlElem[gObj][gEl] <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // ========================================================================
    // Read path: byte value of the addressed register.
    function automatic logic [7:0] pairs_of(input logic [3:0] el);
        integer k;
        pairs_of = 8'h00;
        for (k = 0; k < 4; k++) begin
            pairs_of[k * 2 +: 2] = el[k] ? `PAIR_SET : `PAIR_CLEAR;
        end
    endfunction

    always_comb begin
        rdByte = 8'h00;
        case (arIdx)
            `IDX_CONTROL: rdByte = controlReg;
            `IDX_BIT_TIMING_LOW: rdByte = bitTimingLow;
            `IDX_BIT_TIMING_HIGH: rdByte = {1'b0, bitTimingHigh};
            `IDX_STD_MASK_LOW: rdByte = stdMask[10:3];
            `IDX_STD_MASK_HIGH: rdByte = {stdMask[2:0], `STDH_FILL};
            `IDX_EXT_MASK_BYTE3: rdByte = extMask[28:21];
            `IDX_EXT_MASK_BYTE2: rdByte = extMask[20:13];
            `IDX_EXT_MASK_BYTE1: rdByte = extMask[12:5];
            `IDX_EXT_MASK_BYTE0: rdByte = {extMask[4:0], `LOW3_ZERO};
            `IDX_LAST_MASK_BYTE3: rdByte = lastMask[28:21];
            `IDX_LAST_MASK_BYTE2: rdByte = lastMask[20:13];
            `IDX_LAST_MASK_BYTE1: rdByte = lastMask[12:5];
            `IDX_LAST_MASK_BYTE0: rdByte = {lastMask[4:0], `LOW3_ZERO};
            default: begin
                if (arIdx >= `IDX_OBJ_FIRST && arIdx[3:0] != `OFS_RESERVED) begin
                    if (arIdx[3:0] == `OFS_CTRL_LOW) begin
                        rdByte = pairs_of(ctlElem[arIdx[7:4]][3:0]);
                    end else if (arIdx[3:0] == `OFS_CTRL_HIGH) begin
                        rdByte = pairs_of(ctlElem[arIdx[7:4]][7:4]);
                    end else begin
                        rdByte = objMem[arIdx[7:0]];
                    end
                end
            end
        endcase
    end

    // Read answer registered at the edge that takes the address.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMapped ? {24'h000000, rdByte} : 32'h00000000;
            s_axi_rresp <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ========================================================================
    // Acceptance filter: per-object compare, lowest numbered match wins.
    logic [28:0] globalMask;
    logic [15:1] hit;
    assign globalMask = frameExt ? extMask : {stdMask, 18'h00000};

    generate
        for (gObj = 1; gObj < 16; gObj++) begin : g_match
            logic [28:0] objId;
            logic [28:0] useMask;
            logic objExt;
            assign objId = {objMem[gObj * 16 + 2], objMem[gObj * 16 + 3], objMem[gObj * 16 + 4],
                objMem[gObj * 16 + 5][7:3]};
            assign objExt = objMem[gObj * 16 + 6][`CFG_XTD_BIT];
            // The last object narrows the global mask with its own, typed by the frame's extension bit.
            assign useMask = (gObj == `OBJ_LAST_NUM) ? (globalMask & lastMask) : globalMask;
            assign hit[gObj] = ctlElem[gObj][`ELEM_VALID] && (objExt == frameExt) &&
                (((objId ^ frameId) & useMask) == 29'h00000000);
        end
    endgenerate

    logic anyHit;
    logic [3:0] firstHit;
    always_comb begin
        anyHit = 1'b0;
        firstHit = 4'h0;
        for (int i = 15; i >= 1; i--) begin
            if (hit[i]) begin
                anyHit = 1'b1;
                firstHit = 4'(i);
            end
        end
    end

    // Result is held in flops so the engine sees a clean pulse one cycle after the offer.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            acceptValid <= 1'b0;
            acceptObject <= 4'h0;
        end else begin
            acceptValid <= frameValid && anyHit && !initMode;
            if (frameValid && anyHit) begin
                acceptObject <= firstHit;
            end
        end
    end

    // ========================================================================
    // Bit timing: prescaler, then sync / first / second segment counters.
    logic [5:0] preCnt;
    logic [1:0] resync_jump_width;
    logic [3:0] seg1;
    logic [2:0] seg2;
    assign resync_jump_width = bitTimingLow[`BTL_SJW_HI:`BTL_SJW_LO];
    // Out-of-range segment values are raised to the least legal one rather than stall the bit.
    assign seg1 = (bitTimingHigh[`BTH_SEG1_HI:`BTH_SEG1_LO] < `SEG1_MIN) ? `SEG1_MIN :
        bitTimingHigh[`BTH_SEG1_HI:`BTH_SEG1_LO];
    assign seg2 = (bitTimingHigh[`BTH_SEG2_HI:`BTH_SEG2_LO] < `SEG2_MIN) ? `SEG2_MIN :
        bitTimingHigh[`BTH_SEG2_HI:`BTH_SEG2_LO];

    // Quantum prescaler divides core_clk by the prescaler value plus one.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            preCnt <= 6'h00;
        end else if (initMode || preCnt == bitTimingLow[`BTL_BRP_HI:`BTL_BRP_LO]) begin
            preCnt <= 6'h00;
        end else begin
            preCnt <= preCnt + 6'h01;
        end
    end
    assign quantumTick = !initMode && preCnt == bitTimingLow[`BTL_BRP_HI:`BTL_BRP_LO];

    can_mask_pkg::bit_phase_t phase;
    logic [4:0] segCnt;
    logic [4:0] segEnd;
    logic adjusted;
    logic [4:0] jump;
    assign jump = {3'h0, resync_jump_width} + 5'h01;

    // Segment sequencer; an edge lengthens the first or shortens the second segment once per bit.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phase <= can_mask_pkg::PH_SYNC;
            segCnt <= 5'h00;
            segEnd <= 5'h00;
            adjusted <= 1'b0;
        end else if (initMode) begin
            phase <= can_mask_pkg::PH_SYNC;
            segCnt <= 5'h00;
            segEnd <= 5'h00;
            adjusted <= 1'b0;
        end else if (busEdge && !adjusted && phase == can_mask_pkg::PH_BEFORE) begin
            segEnd <= segEnd + jump;
            adjusted <= 1'b1;
        end else if (busEdge && !adjusted && phase == can_mask_pkg::PH_AFTER) begin
            segEnd <= (segEnd - segCnt <= jump) ? segCnt : segEnd - jump;
            adjusted <= 1'b1;
        end else if (quantumTick) begin
            case (phase)
                can_mask_pkg::PH_SYNC: begin
                    phase <= can_mask_pkg::PH_BEFORE;
                    segCnt <= 5'h00;
                    segEnd <= {1'b0, seg1};
                end
                can_mask_pkg::PH_BEFORE: begin
                    if (segCnt >= segEnd) begin
                        phase <= can_mask_pkg::PH_AFTER;
                        segCnt <= 5'h00;
                        segEnd <= {2'h0, seg2};
                    end else begin
                        segCnt <= segCnt + 5'h01;
                    end
                end
                can_mask_pkg::PH_AFTER: begin
                    if (segCnt >= segEnd) begin
                        phase <= can_mask_pkg::PH_SYNC;
                        adjusted <= 1'b0;
                    end else begin
                        segCnt <= segCnt + 5'h01;
                    end
                end
                default: phase <= can_mask_pkg::PH_SYNC;
            endcase
        end
    end

    assign bitStart = quantumTick && phase == can_mask_pkg::PH_SYNC;
    assign samplePoint = quantumTick && phase == can_mask_pkg::PH_BEFORE && segCnt >= segEnd;

endmodule

// [bench/can_mask_props.sv]
// Checker for the bus answers, filter pulses and bit timing of the CAN mask block.
// Assumes a bind onto the design's top module.
`timescale 1ns/1ps
module can_mask_props (
    input wire logic core_clk, // Clock.
    input wire logic rstn, // Reset, active low.
    input wire logic s_axi_awready, // Write address ready.
    input wire logic s_axi_wready, // Write data ready.
    input wire logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [1:0] s_axi_bresp, // Write response.
    input wire logic s_axi_arready, // Read address ready.
    input wire logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic [31:0] s_axi_rdata, // Read data.
    input wire logic frameValid, // Frame strobe.
    input wire logic acceptValid, // Accept pulse.
    input wire logic [3:0] acceptObject, // Accepting object.
    input wire logic initMode, // Initialisation.
    input wire logic quantumTick, // Quantum pulse.
    input wire logic bitStart, // Bit start pulse.
    input wire logic samplePoint // Sample pulse.
);
    // ========================================================================
    // One clock domain, so clocking and reset are given once.
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped early");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped early");
    property p_wblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && s_axi_bresp[0] == 1'b0; endproperty
    a_wblock: assert property (p_wblock) else $error("write taken while answer pending");
    property p_rbyte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_arready; endproperty
    a_rbyte: assert property (p_rbyte) else $error("read word wider than a byte");
    property p_acc; acceptValid |-> $past(frameValid) && !$past(initMode); endproperty
    a_acc: assert property (p_acc) else $error("accept without frame");
    property p_obj; acceptValid |-> acceptObject != 4'h0; endproperty
    a_obj: assert property (p_obj) else $error("accept names no object");
    property p_quiet; initMode && $past(initMode) |-> !quantumTick && !bitStart && !samplePoint; endproperty
    a_quiet: assert property (p_quiet) else $error("bit timing runs in init");
    property p_sample; samplePoint |-> quantumTick && !bitStart; endproperty
    a_sample: assert property (p_sample) else $error("sample off a quantum");
endmodule
bind can_acceptance_mask_and_object_map can_mask_props chk (.*);

// [bench/can_node_model.sv]
// Remote CAN node: offers received identifiers to the block one frame at a time.
// Assumes a bench that requests frames on core_clk.
`timescale 1ns/1ps
module can_node_model (
    input wire logic core_clk, // Clock.
    input wire logic sendReq, // Bench asks for one frame.
    input wire logic sendExt, // Extension bit to offer.
    input wire logic [28:0] sendId, // Identifier to offer.
    output logic frameValid, // Frame strobe.
    output logic frameExt, // Frame extension bit.
    output logic [28:0] frameId, // Frame identifier.
    output logic busEdge // Bus edge, kept quiet.
);
    // ========================================================================
    // Outside a frame the fields toggle, so a stale value is never trusted.
    always_ff @(posedge core_clk) begin
        frameValid <= sendReq;
        frameExt <= sendReq ? sendExt : ~frameExt;
        frameId <= sendReq ? sendId : ~frameId;
        busEdge <= 1'b0;
    end
endmodule

// [bench/tb_can_acceptance_mask_and_object_map.sv]
// Bench for the CAN mask block: register map, control pairs, filter and bit length.
// Assumes the design, its params header, the node model and the checker.
`timescale 1ns/1ps
`include "can_mask_params.svh"
module tb_can_acceptance_mask_and_object_map;
    logic core_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, got;
    logic [3:0] s_axi_wstrb, acceptObject;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic frameValid, frameExt, busEdge, acceptValid, quantumTick, bitStart, samplePoint, initMode;
    logic [28:0] frameId, sendId;
    logic sendReq, sendExt;
    int fails = 0, nCompared = 0, n;
    can_acceptance_mask_and_object_map dut (.*);
    can_node_model node (.*);
    // ========================================================================
    // Clock and hang guard.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        close_out;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Bus tasks sample the handshake at the edge and release only then.
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [15:0] idx, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        got = s_axi_rdata;
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic rc(input logic [15:0] idx, input logic [7:0] exp);
        rd(idx, 2'h0);
        chk("rdata", got, {24'h000000, exp});
    endtask
    // The node strobes one edge after the request; the answer follows one edge later.
    task automatic frame(input logic ext, input logic [7:0] id, input logic hit, input logic [3:0] obj);
        @(posedge core_clk);
        sendReq <= 1'b1;
        sendExt <= ext;
        sendId <= {id, 21'h000000};
        @(posedge core_clk);
        sendReq <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("accept", {31'h0, acceptValid}, {31'h0, hit});
        chk("object", {28'h0, acceptObject & {4{hit}}}, {28'h0, obj});
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ========================================================================
    // Main sequence.
    initial begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sendReq, sendExt} = 8'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sendId} = 97'h0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        rd(`IDX_BIT_TIMING_HIGH, 2'h0);
        chk("timing top bit", {31'h0, got[7]}, 32'h0);
        wr(`IDX_CONTROL, 8'h41, 2'h0);
        wr(`IDX_BIT_TIMING_LOW, 8'h01, 2'h0);
        wr(`IDX_BIT_TIMING_HIGH, 8'h23, 2'h0);
        wr(`IDX_STD_MASK_HIGH, 8'hE0, 2'h0);
        rc(`IDX_STD_MASK_HIGH, 8'hFF);
        wr(`IDX_EXT_MASK_BYTE0, 8'hFF, 2'h0);
        rc(`IDX_EXT_MASK_BYTE0, 8'hF8);
        wr(`IDX_LAST_MASK_BYTE0, 8'hFF, 2'h0);
        rc(`IDX_LAST_MASK_BYTE0, 8'hF8);
        wr(16'hF701, 8'h00, 2'h2);
        wr(16'hF71F, 8'h00, 2'h2);
        // Every object is put in a known, invalid state before init ends.
        for (n = 1; n < 16; n++) begin
            wr({8'hF7, n[3:0], 4'h0}, 8'h55, 2'h0);
            wr({8'hF7, n[3:0], 4'h2}, {4'h1, n[3:0]}, 2'h0);
        end
        for (n = 1; n < 16; n++) rc({8'hF7, n[3:0], 4'h2}, {4'h1, n[3:0]});
        rc(16'hF710, 8'h55);
        wr(16'hF710, 8'hFE, 2'h0);
        rc(16'hF710, 8'h56);
        wr(16'hF710, 8'h00, 2'h0);
        rc(16'hF710, 8'h56);
        wr(16'hF710, 8'h55, 2'h0);
        for (n = 2; n < 16; n = (n == 3) ? 15 : n + 1) begin
            wr({8'hF7, n[3:0], 4'h3}, 8'h00, 2'h0);
            wr({8'hF7, n[3:0], 4'h6}, 8'h00, 2'h0);
            wr({8'hF7, n[3:0], 4'h0}, 8'hFE, 2'h0);
        end
        wr(`IDX_STD_MASK_LOW, 8'hFF, 2'h0);
        wr(`IDX_LAST_MASK_BYTE3, 8'hF0, 2'h0);
        wr(`IDX_CONTROL, 8'h00, 2'h0);
        wr(`IDX_BIT_TIMING_HIGH, 8'h45, 2'h0);
        rc(`IDX_BIT_TIMING_HIGH, 8'h23);
        frame(1'b0, 8'h13, 1'b1, 4'h3);
        frame(1'b1, 8'h13, 1'b0, 4'h0);
        wr(`IDX_STD_MASK_LOW, 8'hFE, 2'h0);
        frame(1'b0, 8'h13, 1'b1, 4'h2);
        frame(1'b0, 8'h1C, 1'b1, 4'hF);
        // A bit is sync plus both segments, each quantum two clocks here.
        do @(posedge core_clk); while (!bitStart);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!bitStart && n < 100);
        chk("bit length", n, 2 * (1 + (3 + 1) + (2 + 1)));
        rstn <= 1'b0;
        @(posedge core_clk);
        rstn <= 1'b1;
        rc(16'hF730, 8'h56);
        close_out;
    end
endmodule
